// >>> swic_top.sv
// switch interface control: channel gating, state change detection, divider steering
// assumes gate pins and comparator/analog flags arrive asynchronously
`timescale 1ns/1ns
`default_nettype none
module swic_top #(
    parameter int NUM_CH = 8
) (
    input  wire logic                REF_CLK_I,
    input  wire logic                RST_B_I,
    input  wire logic                CMD_VALID_I,
    input  wire swic_pkg::swic_cmd_t CMD_I,
    input  wire logic                SLEEP_REQ_I,
    input  wire logic                LOWPWR_REQ_I,
    input  wire logic [2:0]          GATE_INPUT_I,
    input  wire logic [7:0]          COMPARE_I,
    input  wire logic                OVER_TEMP_I,
    input  wire logic                REF_FAULT_I,
    input  wire logic                IRQ_CLEAR_I,
    output logic [7:0]               SOURCE_ON_O,
    output logic [2:0]               SINK_MODE_O,
    output logic [7:0]               COMPARE_ON_O,
    output logic                     SLOPE_DISABLE_O,
    output logic                     HALF_CURRENT_O,
    output logic                     REF_FALLBACK_O,
    output swic_pkg::swic_div_t      DIVIDER_SEL_O,
    output logic [2:0]               DIVIDER_CH_O,
    output logic [7:0]               CHANNEL_COMPARE_STATUS_O,
    output logic [7:0]               CHANGE_DETECTED_O,
    output swic_pkg::swic_mode_t     MODE_O,
    output logic                     IRQ_N_O,
    output logic                     IRQ_N_OE_O,
    output logic                     WAKE_O
);
    import swic_pkg::*;

    logic [2:0]        gate_s1, gate_s2, gate_q;
    logic [7:0]        cmp_s1, cmp_s2;
    logic [1:0]        ana_s1, ana_s2;
    logic [7:0]        source_enable, direct_on, change_irq_enable, direct_q;
    logic [2:0]        sink_select;
    logic [7:0]        prev_sample, sample_valid;
    logic [7:0]        next_source_on, fall_evt, change_evt, chan_gate;
    logic              gate_rise, thermal_evt;
    logic              ot_q;
    swic_mode_t        mode;

    // two-stage synchronisers, first stage read by nothing else
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            gate_s1 <= 3'h0;
            gate_s2 <= 3'h0;
            cmp_s1  <= 8'h00;
            cmp_s2  <= 8'h00;
            ana_s1  <= 2'h0;
            ana_s2  <= 2'h0;
        end else begin
            gate_s1 <= GATE_INPUT_I;
            gate_s2 <= gate_s1;
            cmp_s1  <= COMPARE_I;
            cmp_s2  <= cmp_s1;
            ana_s1  <= {OVER_TEMP_I, REF_FAULT_I};
            ana_s2  <= ana_s1;
        end
    end

    // per-channel configuration
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            source_enable     <= 8'h00;
            direct_on         <= 8'h00;
            change_irq_enable <= 8'h00;
            sink_select       <= 3'h0;
        end else if (CMD_VALID_I && CMD_I.channel_program_enable) begin
            source_enable[CMD_I.channel_select]     <= CMD_I.source_enable;
            direct_on[CMD_I.channel_select]         <= CMD_I.direct_on;
            change_irq_enable[CMD_I.channel_select] <= CMD_I.change_irq_enable;
            if (CMD_I.channel_select < 3'(NUM_SINK)) begin
                sink_select[CMD_I.channel_select[1:0]] <= CMD_I.sink_select;
            end
        end
    end

    // global configuration and divider steering
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SLOPE_DISABLE_O <= 1'b0;
            HALF_CURRENT_O  <= 1'b0;
            DIVIDER_SEL_O   <= SWIC_DIV_OFF;
            DIVIDER_CH_O    <= 3'h0;
        end else begin
            if (CMD_VALID_I) begin
                if (!CMD_I.channel_program_enable) begin
                    SLOPE_DISABLE_O <= CMD_I.slope_disable;
                end
                HALF_CURRENT_O <= CMD_I.half_current;
                DIVIDER_CH_O   <= CMD_I.channel_select;
                if (!CMD_I.divider_enable) begin
                    DIVIDER_SEL_O <= SWIC_DIV_OFF;
                end else if (CMD_I.divider_source) begin
                    DIVIDER_SEL_O <= SWIC_DIV_CHAN;
                end else begin
                    DIVIDER_SEL_O <= SWIC_DIV_BATT;
                end
            end
            if (mode == SWIC_SLEEP) begin
                DIVIDER_SEL_O <= SWIC_DIV_OFF;
            end
        end
    end

    // source gating per channel
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign chan_gate[g] = gate_s2[GATE_OF_CH[g]];
            assign next_source_on[g] = source_enable[g] && (direct_on[g] || chan_gate[g])
                                       && !ana_s2[1] && (mode == SWIC_ACTIVE);
            // direct_on falling or gate falling ends the on-phase
            assign fall_evt[g] = source_enable[g] &&
                                 ((direct_q[g] && !direct_on[g]) ||
                                  (!direct_on[g] && gate_q[GATE_OF_CH[g]] && !chan_gate[g]));
            assign change_evt[g] = fall_evt[g] && sample_valid[g] &&
                                   (cmp_s2[g] != prev_sample[g]);
        end
    endgenerate

    assign gate_rise   = |(gate_s2 & ~gate_q);
    assign thermal_evt = ana_s2[1] && !ot_q;

    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            gate_q   <= 3'h0;
            direct_q <= 8'h00;
            ot_q     <= 1'b0;
        end else begin
            gate_q   <= gate_s2;
            direct_q <= direct_on;
            ot_q     <= ana_s2[1];
        end
    end

    // mode control; sleep and low-power requests come from the main controller
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            mode <= SWIC_ACTIVE;
        end else begin
            unique case (mode)
                SWIC_SLEEP: begin
                    if (!SLEEP_REQ_I) mode <= SWIC_ACTIVE;
                end
                SWIC_ACTIVE: begin
                    if (SLEEP_REQ_I) begin
                        mode <= SWIC_SLEEP;
                    end else if (LOWPWR_REQ_I && ~|(source_enable & direct_on)
                                 && ~|(source_enable & chan_gate)) begin
                        mode <= SWIC_LOWPWR;
                    end
                end
                SWIC_LOWPWR: begin
                    if (SLEEP_REQ_I) begin
                        mode <= SWIC_SLEEP;
                    end else if (gate_rise || |change_evt || !LOWPWR_REQ_I) begin
                        mode <= SWIC_ACTIVE;
                    end
                end
                default: mode <= SWIC_ACTIVE;
            endcase
        end
    end

    // outputs to the analog side
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            SOURCE_ON_O    <= 8'h00;
            COMPARE_ON_O   <= 8'h00;
            SINK_MODE_O    <= 3'h0;
            REF_FALLBACK_O <= 1'b0;
            MODE_O         <= SWIC_ACTIVE;
        end else begin
            SOURCE_ON_O    <= next_source_on;
            COMPARE_ON_O   <= next_source_on;
            SINK_MODE_O    <= sink_select;
            REF_FALLBACK_O <= ana_s2[0];
            MODE_O         <= mode;
        end
    end

    // state change detection; status mirrors the synchronised comparator
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            prev_sample  <= 8'h00;
            sample_valid <= 8'h00;
            CHANNEL_COMPARE_STATUS_O <= 8'h00;
        end else begin
            CHANNEL_COMPARE_STATUS_O <= cmp_s2;
            for (int i = 0; i < NUM_CH; i++) begin
                if (!source_enable[i]) begin
                    sample_valid[i] <= 1'b0;
                end else if (fall_evt[i]) begin
                    prev_sample[i]  <= cmp_s2[i];
                    sample_valid[i] <= 1'b1;
                end
            end
        end
    end

    // sticky change and irq-drive flags: set wins over clear; wake is a one-cycle pulse
    always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            CHANGE_DETECTED_O <= 8'h00;
            IRQ_N_O           <= 1'b1;
            IRQ_N_OE_O        <= 1'b0;
            WAKE_O            <= 1'b0;
        end else begin
            CHANGE_DETECTED_O <= (IRQ_CLEAR_I ? 8'h00 : CHANGE_DETECTED_O) | change_evt;
            if (|(change_evt & change_irq_enable) || thermal_evt) begin
                IRQ_N_OE_O <= 1'b1;
            end else if (IRQ_CLEAR_I) begin
                IRQ_N_OE_O <= 1'b0;
            end
            IRQ_N_O <= 1'b0;
            WAKE_O  <= (mode == SWIC_LOWPWR) && |change_evt;
        end
    end

    property p_irq_on_change;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            |(change_evt & change_irq_enable) |=> IRQ_N_OE_O;
    endproperty
    a_irq_on_change: assert property (p_irq_on_change)
        else $error("irq not driven after change");
    property p_off_when_not_active;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            (mode != SWIC_ACTIVE) |=> SOURCE_ON_O == 8'h00;
    endproperty
    a_off_when_not_active: assert property (p_off_when_not_active)
        else $error("source on outside active mode");
    property p_disabled_off;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            (source_enable == 8'h00) |=> SOURCE_ON_O == 8'h00;
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("disabled source on");
    property p_thermal_off;
        @(posedge REF_CLK_I) disable iff (!RST_B_I) ana_s2[1] |=> SOURCE_ON_O == 8'h00;
    endproperty
    a_thermal_off: assert property (p_thermal_off)
        else $error("source on during over-temperature");
    property p_slope_hold;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            (CMD_VALID_I && CMD_I.channel_program_enable) |=> $stable(SLOPE_DISABLE_O);
    endproperty
    a_slope_hold: assert property (p_slope_hold)
        else $error("slope bit changed by channel command");
    property p_sleep_div_off;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            (mode == SWIC_SLEEP) |=> DIVIDER_SEL_O == SWIC_DIV_OFF;
    endproperty
    a_sleep_div_off: assert property (p_sleep_div_off)
        else $error("divider on in sleep");
    // the pin stays pulled low until software clears it
    property p_irq_hold;
        @(posedge REF_CLK_I) disable iff (!RST_B_I) (IRQ_N_OE_O && !IRQ_CLEAR_I) |=> IRQ_N_OE_O;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq drive dropped without clear");
    property p_change_flag;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            (|change_evt) |=> ((CHANGE_DETECTED_O & $past(change_evt)) == $past(change_evt));
    endproperty
    a_change_flag: assert property (p_change_flag)
        else $error("change flag missing after state change");
    // wake is a single pulse because the mode leaves low-power on the same edge
    sequence s_lowpwr_change;
        (mode == SWIC_LOWPWR) && (|change_evt);
    endsequence
    property p_wake_on_change;
        @(posedge REF_CLK_I) disable iff (!RST_B_I) s_lowpwr_change |=> WAKE_O ##1 !WAKE_O;
    endproperty
    a_wake_on_change: assert property (p_wake_on_change)
        else $error("no single wake pulse after change in low-power");
    property p_div_chan;
        @(posedge REF_CLK_I) disable iff (!RST_B_I)
            (CMD_VALID_I && CMD_I.divider_enable && CMD_I.divider_source && mode != SWIC_SLEEP)
            |=> (DIVIDER_SEL_O == SWIC_DIV_CHAN)
                && (DIVIDER_CH_O == $past(CMD_I.channel_select));
    endproperty
    a_div_chan: assert property (p_div_chan)
        else $error("divider not steered to addressed channel");
endmodule // swic_top
`default_nettype wire

// >>> swic_pkg.sv
// package of the switch interface control block: types and constants
// assumes a single 20 MHz clock domain and no register bus
package swic_pkg;
    localparam int NUM_CH   = 8;
    localparam int NUM_GATE = 3;
    localparam int NUM_SINK = 3;
    localparam int RATIO_FULL = 100;
    localparam int RATIO_HALF = 50;

    typedef enum logic [2:0] {
        SWIC_SLEEP  = 3'b001,
        SWIC_ACTIVE = 3'b010,
        SWIC_LOWPWR = 3'b100
    } swic_mode_t;

    typedef enum logic [2:0] {
        SWIC_DIV_OFF  = 3'b001,
        SWIC_DIV_BATT = 3'b010,
        SWIC_DIV_CHAN = 3'b100
    } swic_div_t;

    // one command word as decoded from the serial port
    typedef struct packed {
        logic       channel_program_enable;
        logic [2:0] channel_select;
        logic       source_enable;
        logic       sink_select;
        logic       change_irq_enable;
        logic       direct_on;
        logic       slope_disable;
        logic       half_current;
        logic       divider_enable;
        logic       divider_source;
    } swic_cmd_t;

    // gate group of each channel, channel 0 first
    localparam logic [1:0] GATE_OF_CH [NUM_CH] = '{2'h0, 2'h1, 2'h2, 2'h2,
                                                   2'h1, 2'h1, 2'h0, 2'h0};
endpackage

// >>> swic_mcu.sv
// microcontroller model: sends decoded command words and drives the gate pins
// assumes the block samples its inputs on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module swic_mcu (
    input  wire logic                clk_i,
    output var  logic                cmd_valid_o,
    output var  swic_pkg::swic_cmd_t cmd_o,
    output var  logic [2:0]          gate_o
);
    import swic_pkg::*;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
        gate_o      = 3'h0;
    end
    task automatic send(input swic_cmd_t c);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o       <= ~c; // released word never shows the stale value
    endtask
    task automatic prog(input logic [2:0] ch, input logic en, snk, irq, dir);
        swic_cmd_t c;
        c = '0;
        c.channel_program_enable = 1'b1;
        c.channel_select = ch;
        c.source_enable = en;
        c.sink_select = snk;
        c.change_irq_enable = irq;
        c.direct_on = dir;
        send(c);
    endtask
    task automatic glob(input logic slope, dive, divp, input logic [2:0] ch);
        swic_cmd_t c;
        c = '0;
        c.channel_program_enable = 1'b0;
        c.slope_disable = slope;
        c.divider_enable = dive;
        c.divider_source = divp;
        c.channel_select = ch;
        send(c);
    endtask
    task automatic gate(input logic [2:0] g);
        @(posedge clk_i);
        gate_o <= g;
    endtask
endmodule // swic_mcu
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the switch interface control block
// assumes the microcontroller model drives commands and gate pins
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import swic_pkg::*;
    typedef struct packed {logic [3:0] sel; logic [7:0] exp;} swic_note_t;
    logic clk, rst_b, sleep_req, lowpwr_req, over_temp, ref_fault, irq_clear, cmd_valid;
    logic slope, half, ref_fb, irq_n, irq_oe, wake;
    logic [7:0] compare, src, cmp_on, status, change, exp;
    logic [2:0] gate, sink, div_ch;
    swic_cmd_t cmd, c;
    swic_div_t div_sel;
    swic_mode_t mode;
    swic_note_t q[$];
    swic_note_t nt;
    event ev_obs;
    int error_cnt = 0;
    int n_checks = 0;
    int i;
    logic [15:0] lfsr_q = 16'h41FF;
    logic [7:0] gmask [3] = '{8'hC1, 8'h32, 8'h0C};
    swic_mcu mcu_u (.clk_i(clk), .cmd_valid_o(cmd_valid), .cmd_o(cmd), .gate_o(gate));
    swic_top dut_u (.REF_CLK_I(clk), .RST_B_I(rst_b), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
        .SLEEP_REQ_I(sleep_req), .LOWPWR_REQ_I(lowpwr_req), .GATE_INPUT_I(gate),
        .COMPARE_I(compare), .OVER_TEMP_I(over_temp), .REF_FAULT_I(ref_fault),
        .IRQ_CLEAR_I(irq_clear), .SOURCE_ON_O(src), .SINK_MODE_O(sink),
        .COMPARE_ON_O(cmp_on), .SLOPE_DISABLE_O(slope), .HALF_CURRENT_O(half),
        .REF_FALLBACK_O(ref_fb), .DIVIDER_SEL_O(div_sel), .DIVIDER_CH_O(div_ch),
        .CHANNEL_COMPARE_STATUS_O(status), .CHANGE_DETECTED_O(change), .MODE_O(mode),
        .IRQ_N_O(irq_n), .IRQ_N_OE_O(irq_oe), .WAKE_O(wake));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] observe(input logic [3:0] sel);
        case (sel)
            4'h0: return src;
            4'h1: return cmp_on;
            4'h2: return {5'h00, sink};
            4'h3: return status;
            4'h4: return change;
            4'h5: return {7'h00, irq_oe};
            4'h6: return {5'h00, mode};
            4'h7: return {5'h00, div_sel};
            4'h8: return {5'h00, div_ch};
            4'h9: return {7'h00, slope};
            4'hA: return {7'h00, half};
            4'hB: return {7'h00, ref_fb};
            4'hD: return {7'h00, wake};
            default: return {7'h00, irq_n};
        endcase
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic note(input logic [3:0] sel, input logic [7:0] want);
        q.push_back('{sel, want});
        -> ev_obs;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial forever begin
        @(ev_obs);
        while (q.size() > 0) begin
            nt = q.pop_front();
            check(observe(nt.sel), nt.exp);
        end
    end
    initial begin
        #400000;
        error_cnt++;
        stop_test;
    end
    initial begin
        {rst_b, sleep_req, lowpwr_req, over_temp, ref_fault, irq_clear} = 6'h00;
        compare = 8'h00;
        wt(15);
        note(4'h6, SWIC_ACTIVE);
        note(4'h7, SWIC_DIV_OFF);
        note(4'hC, 8'h01);
        @(posedge clk);
        rst_b <= 1'b1;
        exp = 8'h00;
        for (i = 0; i < 8; i++) begin
            mcu_u.prog(i[2:0], 1'b1, 1'b0, 1'b0, 1'b1);
            exp[i] = 1'b1;
            wt(2);
            note(4'h0, exp);
            note(4'h1, exp);
        end
        for (i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            c = swic_cmd_t'(lfsr_q[11:0]);
            c.channel_program_enable = 1'b0;
            c.source_enable = 1'b0;
            mcu_u.send(c);
            wt(2);
            note(4'h0, 8'hFF);
            note(4'h9, {7'h00, c.slope_disable});
            note(4'hA, {7'h00, c.half_current});
        end
        mcu_u.glob(1'b1, 1'b0, 1'b0, 3'h0);
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b0, 1'b1);
        wt(2);
        note(4'h9, 8'h01);
        for (i = 0; i < 4; i++) mcu_u.prog(i[2:0], 1'b1, 1'b1, 1'b0, 1'b1);
        wt(2);
        note(4'h2, 8'h07);
        for (i = 0; i < 10; i++) begin
            mcu_u.glob(1'b1, i > 0, i > 1, i[2:0]);
            wt(2);
            note(4'h7, i == 0 ? SWIC_DIV_OFF : (i == 1 ? SWIC_DIV_BATT : SWIC_DIV_CHAN));
            if (i > 1) note(4'h8, {5'h00, i[2:0]});
        end
        for (i = 0; i < 8; i++) mcu_u.prog(i[2:0], 1'b1, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 3; i++) begin
            mcu_u.gate(3'h1 << i);
            wt(5);
            note(4'h0, gmask[i]);
        end
        mcu_u.gate(3'h0);
        lowpwr_req <= 1'b1;
        wt(5);
        note(4'h0, 8'h00);
        note(4'h6, SWIC_LOWPWR);
        mcu_u.gate(3'h4);
        wt(5);
        note(4'h6, SWIC_ACTIVE);
        note(4'h0, 8'h0C);
        mcu_u.gate(3'h0);
        lowpwr_req <= 1'b0;
        mcu_u.prog(3'h3, 1'b1, 1'b0, 1'b0, 1'b1);
        over_temp <= 1'b1;
        wt(5);
        note(4'h0, 8'h00);
        note(4'h5, 8'h01);
        note(4'hC, 8'h00);
        @(posedge clk);
        over_temp <= 1'b0;
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        wt(5);
        note(4'h0, 8'h08);
        note(4'h5, 8'h00);
        // disable first so the next enable starts with no valid sample
        @(posedge clk);
        compare <= 8'h01;
        mcu_u.prog(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b1, 1'b1);
        wt(4);
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        wt(4);
        note(4'h3, 8'h01);
        note(4'h4, 8'h00);
        note(4'h5, 8'h00);
        @(posedge clk);
        compare <= 8'h00;
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b1, 1'b1);
        wt(4);
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        wt(4);
        note(4'h3, 8'h00);
        note(4'h4, 8'h01);
        note(4'h5, 8'h01);
        @(posedge clk);
        compare <= 8'h01;
        lowpwr_req <= 1'b1;
        mcu_u.prog(3'h3, 1'b1, 1'b0, 1'b0, 1'b0);
        wt(5);
        note(4'h6, SWIC_LOWPWR);
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b1, 1'b1);
        mcu_u.prog(3'h0, 1'b1, 1'b0, 1'b1, 1'b0);
        wt(1);
        note(4'hD, 8'h01);
        @(posedge clk);
        lowpwr_req <= 1'b0;
        sleep_req <= 1'b1;
        ref_fault <= 1'b1;
        wt(5);
        note(4'h0, 8'h00);
        note(4'h1, 8'h00);
        note(4'h6, SWIC_SLEEP);
        note(4'h7, SWIC_DIV_OFF);
        note(4'hB, 8'h01);
        wt(1);
        stop_test;
    end
endmodule // tb_top
`default_nettype wire
